/* File: mau_regs.vh */
// Register selects, field positions, reset values and timing for the multiply-accumulate unit
`ifndef MAU_REGS_VH
`define MAU_REGS_VH
// ****************************************************************
// Debug register selects
// ****************************************************************
`define MAU_SEL_STATUS      12'h804
`define MAU_SEL_MASK        12'h805
`define MAU_SEL_ACC         12'h806
// ****************************************************************
// Status/control fields and reset values
// ****************************************************************
`define MAU_BIT_SAT         7
`define MAU_BIT_SU          6
`define MAU_BIT_FI          5
`define MAU_BIT_RT          4
`define MAU_BIT_NEG         3
`define MAU_BIT_ZERO        2
`define MAU_BIT_OVF         1
`define MAU_STATUS_RST      32'h0000_0000
`define MAU_MASK_RST        32'hFFFF_FFFF
`define MAU_STATUS_WMASK    32'h0000_00FF
// ****************************************************************
// Cycles the issue port stays blocked after an issue (index of the last pass)
// ****************************************************************
`define MAU_II_WORD         2'h0
`define MAU_II_LINT         2'h2
`define MAU_II_LFRAC        2'h3
// ****************************************************************
// Saturation constants
// ****************************************************************
`define MAU_SMAX            32'h7FFF_FFFF
`define MAU_SMIN            32'h8000_0000
`define MAU_UMAX            32'hFFFF_FFFF
`define MAU_UMIN            32'h0000_0000
`endif

/* File: mau_mul16.v */
// Pipelined 16x16 multiply array, one register stage
`default_nettype none
module mau_mul16 (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Operands, each extended by one sign bit
  input  wire [16:0] a_i,
  input  wire [16:0] b_i,
  // Product
  output reg  [33:0] p_o
);
  // ****************************************************************
  // Array
  // ****************************************************************
  // Signed 17x17 covers both signed and unsigned 16-bit halves
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      p_o <= 34'h0;
    end else begin
      p_o <= $signed(a_i) * $signed(b_i);
    end
  end
endmodule // mau_mul16
`default_nettype wire

/* File: mau_core.v */
// Multiply-accumulate unit: pipeline, accumulator, status and mask registers
`include "mau_regs.vh"
`default_nettype none
module mau_core (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Operation issue from the operand execution pipeline
  input  wire        op_valid_i,
  input  wire        op_long_i,
  input  wire        op_sub_i,
  input  wire        op_mul_only_i,
  input  wire [1:0]  op_shift_i,
  input  wire [31:0] op_x_i,
  input  wire [31:0] op_y_i,
  output wire        op_ready_o,
  output reg         mul_valid_o,
  output reg  [31:0] mul_result_o,
  // Parallel operand load address path
  input  wire [31:0] ld_addr_i,
  input  wire        ld_use_mask_i,
  output wire [31:0] ld_addr_o,
  // Accumulator move to a general register
  output reg  [31:0] acc_move_o,
  // Register access, core moves and background debug port
  input  wire        reg_wr_i,
  input  wire [11:0] reg_sel_i,
  input  wire [31:0] reg_wdata_i,
  output reg  [31:0] reg_rdata_o
);
  // ****************************************************************
  // State
  // ****************************************************************
  reg  [31:0] status_q, mask_q, acc_q, x_q, y_q;
  reg  [63:0] psum_q, s2_prod_q, pshift;
  reg  [31:0] prod32, sprod, sat_val;
  reg  [1:0]  pass_q, npass_q, sh_q, s1_pass_q, s1_sh_q, s2_sh_q;
  reg         busy_q, sub_q, mulo_q, long_q, reload_q;
  reg         s1_v_q, s1_last_q, s1_sub_q, s1_mulo_q, s1_long_q;
  reg         s2_v_q, s2_sub_q, s2_mulo_q, s2_long_q;
  wire        sat_en = status_q[`MAU_BIT_SAT];
  wire        uns    = status_q[`MAU_BIT_SU];
  wire        frac   = status_q[`MAU_BIT_FI];
  wire        rnd    = status_q[`MAU_BIT_RT];
  wire        ovf    = status_q[`MAU_BIT_OVF];
  wire        sgn    = ~uns | frac;
  // ****************************************************************
  // Operand selection for the array
  // ****************************************************************
  // Long pass order: lo*lo, hi(x)*lo(y), lo(x)*hi(y), hi*hi (fraction only)
  wire [1:0]  cur_pass = busy_q ? pass_q : 2'h0;
  wire [31:0] cx = busy_q ? x_q : op_x_i;
  wire [31:0] cy = busy_q ? y_q : op_y_i;
  wire        clong = busy_q ? long_q : op_long_i;
  wire [15:0] ax = cur_pass[0] ? cx[31:16] : cx[15:0];
  wire [15:0] ay = cur_pass[1] ? cy[31:16] : cy[15:0];
  // Low halves of long operands are unsigned partials
  wire        ax_s = sgn & (~clong | cur_pass[0]);
  wire        ay_s = sgn & (~clong | cur_pass[1]);
  wire [16:0] a17 = {ax_s & ax[15], ax};
  wire [16:0] b17 = {ay_s & ay[15], ay};
  wire [33:0] arr_p;
  wire        issue = op_valid_i & ~busy_q;
  // Word ops issue every cycle; long ops hold the port for their passes
  assign op_ready_o = ~busy_q;
  mau_mul16 u_mul (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .a_i     (a17),
    .b_i     (b17),
    .p_o     (arr_p)
  );
  // ****************************************************************
  // Stage 1: issue and pass sequencing
  // ****************************************************************
  // Pass count fixed by size and mode, never by operand values
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_q  <= 1'b0;
      pass_q  <= 2'h0;
      npass_q <= 2'h0;
      x_q     <= 32'h0;
      y_q     <= 32'h0;
      sub_q   <= 1'b0;
      mulo_q  <= 1'b0;
      sh_q    <= 2'h0;
      long_q  <= 1'b0;
    end else if (issue) begin
      x_q    <= op_x_i;
      y_q    <= op_y_i;
      sub_q  <= op_sub_i;
      mulo_q <= op_mul_only_i;
      sh_q   <= op_shift_i;
      long_q <= op_long_i;
      if (op_long_i) begin
        busy_q  <= 1'b1;
        pass_q  <= 2'h1;
        npass_q <= (frac & ~op_mul_only_i) ? `MAU_II_LFRAC : `MAU_II_LINT;
      end
    end else if (busy_q) begin
      pass_q <= pass_q + 2'h1;
      if (pass_q == npass_q) begin
        busy_q <= 1'b0;
      end
    end
  end
  // Tag each array pass travelling with the product
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_v_q    <= 1'b0;
      s1_last_q <= 1'b0;
      s1_pass_q <= 2'h0;
      s1_sub_q  <= 1'b0;
      s1_mulo_q <= 1'b0;
      s1_sh_q   <= 2'h0;
      s1_long_q <= 1'b0;
    end else begin
      s1_v_q    <= issue | busy_q;
      s1_last_q <= (issue & ~op_long_i) | (busy_q & (pass_q == npass_q));
      s1_pass_q <= cur_pass;
      s1_sub_q  <= busy_q ? sub_q : op_sub_i;
      s1_mulo_q <= busy_q ? mulo_q : op_mul_only_i;
      s1_sh_q   <= busy_q ? sh_q : op_shift_i;
      s1_long_q <= clong;
    end
  end
  // ****************************************************************
  // Stage 2: partial product summation
  // ****************************************************************
  wire [63:0] pext = {{30{arr_p[33]}}, arr_p};
  always @* begin
    case (s1_pass_q)
      2'h0:    pshift = pext;
      2'h1:    pshift = {pext[47:0], 16'h0};
      2'h2:    pshift = {pext[47:0], 16'h0};
      default: pshift = {pext[31:0], 32'h0};
    endcase
  end
  wire [63:0] psum_d = (s1_pass_q == 2'h0) ? pshift : psum_q + pshift;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      psum_q    <= 64'h0;
      s2_v_q    <= 1'b0;
      s2_prod_q <= 64'h0;
      s2_sub_q  <= 1'b0;
      s2_mulo_q <= 1'b0;
      s2_sh_q   <= 2'h0;
      s2_long_q <= 1'b0;
    end else begin
      if (s1_v_q) begin
        psum_q <= psum_d;
      end
      s2_v_q    <= s1_v_q & s1_last_q;
      s2_prod_q <= psum_d;
      s2_sub_q  <= s1_sub_q;
      s2_mulo_q <= s1_mulo_q;
      s2_sh_q   <= s1_sh_q;
      s2_long_q <= s1_long_q;
    end
  end
  // ****************************************************************
  // Stage 3: scale, accumulate, saturate
  // ****************************************************************
  // Fraction: 1.15x1.15 -> 1.31 by left shift; long keeps upper word
  wire [63:0] fprod = {s2_prod_q[62:0], 1'b0};
  wire        tie_up = fprod[31] & ((|fprod[30:0]) | fprod[32]);
  wire [31:0] frac_l = fprod[63:32] + {31'h0, rnd & tie_up};
  always @* begin
    if (!frac) begin
      prod32 = s2_prod_q[31:0];
    end else if (s2_long_q) begin
      prod32 = frac_l;
    end else begin
      prod32 = fprod[31:0];
    end
  end
  always @* begin
    case (s2_sh_q)
      2'h1:    sprod = {prod32[30:0], 1'b0};
      2'h2:    sprod = {sgn & prod32[31], prod32[31:1]};
      default: sprod = prod32;
    endcase
  end
  // Extra sign bit exposes overflow for both signedness modes
  wire [32:0] acc_e = {sgn & acc_q[31], acc_q};
  wire [32:0] prd_e = {sgn & sprod[31], sprod};
  wire [32:0] sum_e = s2_sub_q ? acc_e - prd_e : acc_e + prd_e;
  wire        ov_s  = sum_e[32] ^ sum_e[31];
  wire        ov    = sgn ? ov_s : sum_e[32];
  always @* begin
    if (sgn) begin
      sat_val = sum_e[32] ? `MAU_SMIN : `MAU_SMAX;
    end else begin
      sat_val = s2_sub_q ? `MAU_UMIN : `MAU_UMAX;
    end
  end
  wire        acc_op   = s2_v_q & ~s2_mulo_q;
  wire        acc_lock = sat_en & ovf & ~reload_q;
  wire [31:0] acc_new  = (ov & sat_en) ? sat_val : sum_e[31:0];
  wire        wr_st    = reg_wr_i & (reg_sel_i == `MAU_SEL_STATUS);
  wire        wr_acc   = reg_wr_i & (reg_sel_i == `MAU_SEL_ACC);
  wire        acc_upd  = acc_op & ~acc_lock & ~wr_acc;
  // Accumulator has no reset; a direct load beats an operation in flight
  always @(posedge clk_i) begin
    if (wr_acc) begin
      acc_q <= reg_wdata_i;
    end else if (acc_upd) begin
      acc_q <= acc_new;
    end
  end
  // Multiply-only result to a data register
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      mul_valid_o  <= 1'b0;
      mul_result_o <= 32'h0;
    end else begin
      mul_valid_o  <= s2_v_q & s2_mulo_q;
      mul_result_o <= s2_prod_q[31:0];
    end
  end
  // ****************************************************************
  // Status and mask registers
  // ****************************************************************
  // Overflow set wins over a software clear in the same cycle
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_q <= `MAU_STATUS_RST;
      mask_q   <= `MAU_MASK_RST;
      reload_q <= 1'b0;
    end else begin
      if (wr_st) begin
        status_q <= reg_wdata_i & `MAU_STATUS_WMASK;
      end
      if (acc_upd) begin
        status_q[`MAU_BIT_NEG]  <= acc_new[31];
        status_q[`MAU_BIT_ZERO] <= (acc_new == 32'h0);
        if (ov) begin
          status_q[`MAU_BIT_OVF] <= 1'b1;
        end
      end
      if (reg_wr_i & (reg_sel_i == `MAU_SEL_MASK)) begin
        mask_q <= reg_wdata_i;
      end
      // Direct load lifts the saturation hold; the flag itself stays set
      reload_q <= wr_acc | (reload_q & ~(acc_upd & ov & sat_en));
    end
  end
  // Circular queue: masked bits of the incremented address stay fixed
  assign ld_addr_o = ld_use_mask_i ? (ld_addr_i & mask_q) : ld_addr_i;
  // ****************************************************************
  // Reads and accumulator moves
  // ****************************************************************
  wire [16:0] r16 = {1'b0, acc_q[31:16]} +
                    {16'h0, acc_q[15] & ((|acc_q[14:0]) | acc_q[16])};
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      acc_move_o <= 32'h0;
    end else if (frac & uns) begin
      acc_move_o <= {16'h0, r16[15:0]};
    end else begin
      acc_move_o <= acc_q;
    end
  end
  // Selects follow the debug register numbering
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0;
    end else begin
      case (reg_sel_i)
        `MAU_SEL_STATUS: reg_rdata_o <= status_q;
        `MAU_SEL_MASK:   reg_rdata_o <= mask_q;
        `MAU_SEL_ACC:    reg_rdata_o <= acc_q;
        default:         reg_rdata_o <= 32'h0;
      endcase
    end
  end
endmodule // mau_core
`default_nettype wire

/* File: mau_core_monitor.sv */
// Port-level checker for the multiply-accumulate unit
`include "mau_regs.vh"
`default_nettype none
module mau_core_monitor (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // Operation issue and load address
  input wire logic        op_valid_i,
  input wire logic        op_long_i,
  input wire logic        op_mul_only_i,
  input wire logic        op_ready_o,
  input wire logic        mul_valid_o,
  input wire logic [31:0] ld_addr_i,
  input wire logic        ld_use_mask_i,
  input wire logic [31:0] ld_addr_o,
  // Register access
  input wire logic        reg_wr_i,
  input wire logic [11:0] reg_sel_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mask_q;
  logic [3:0]  mode_q;
  wire logic   take;
  wire logic   frac_mac;
  assign take = op_valid_i & op_ready_o;
  // Long fraction MAC takes an extra pass, a plain long multiply does not
  assign frac_mac = mode_q[1] & ~op_mul_only_i;
  // Shadow of written mask and mode bits; flags are the unit's own
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mask_q <= `MAU_MASK_RST;
      mode_q <= 4'h0;
    end else if (reg_wr_i) begin
      if (reg_sel_i == `MAU_SEL_MASK) mask_q <= reg_wdata_i;
      if (reg_sel_i == `MAU_SEL_STATUS) mode_q <= reg_wdata_i[7:4];
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_word_lat: assert property (
    take && !op_long_i && op_mul_only_i |-> ##[3:4] mul_valid_o)
    else $error("word multiply result not on time");
  chk_long_lat: assert property (
    take && op_long_i && op_mul_only_i |-> ##[5:6] mul_valid_o)
    else $error("long multiply result not on time");
  chk_word_issue: assert property (
    take && !op_long_i |=> op_ready_o)
    else $error("word op blocked the next issue");
  chk_long_issue: assert property (
    take && op_long_i && !frac_mac |=> !op_ready_o [*2] ##1 op_ready_o)
    else $error("long integer issue spacing wrong");
  chk_frac_issue: assert property (
    take && op_long_i && frac_mac |=> !op_ready_o [*3] ##1 op_ready_o)
    else $error("long fraction issue spacing wrong");
  chk_mask_addr: assert property (
    ld_addr_o == (ld_use_mask_i ? (ld_addr_i & mask_q) : ld_addr_i))
    else $error("load address masking wrong");
  chk_mask_read: assert property (
    !reg_wr_i && reg_sel_i == `MAU_SEL_MASK |=> reg_rdata_o == $past(mask_q))
    else $error("mask read back wrong");
  chk_status_read: assert property (
    !reg_wr_i && reg_sel_i == `MAU_SEL_STATUS |=> reg_rdata_o[31:4] == {24'h0, $past(mode_q)})
    else $error("status mode bits read back wrong");
  cov_long: cover property (take && op_long_i && !frac_mac);
  cov_frac: cover property (take && op_long_i && frac_mac);
  cov_b2b: cover property (take && !op_long_i ##1 take);
endmodule // mau_core_monitor
`default_nettype wire

/* File: mau_ld_partner.sv */
// Model of the core's post-increment operand address generator
`default_nettype none
module mau_ld_partner (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Address step and current address
  input  wire logic        step_i,
  output var  logic [31:0] addr_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Steps one longword per load; wrapping is the unit's job, not ours
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      addr_o <= 32'h0000_10F8;
    end else if (step_i) begin
      addr_o <= addr_o + 32'h0000_0004;
    end
  end
endmodule // mau_ld_partner
`default_nettype wire

/* File: mau_core_bench.sv */
// Self-checking bench for the multiply-accumulate unit
`include "mau_regs.vh"
`default_nettype none
module mau_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] ST = `MAU_SEL_STATUS, MK = `MAU_SEL_MASK, AC = `MAU_SEL_ACC;
  localparam logic [31:0] F = 32'hFFFF_FFFF;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, op_valid_i = 1'b0, reg_wr_i = 1'b0;
  logic        op_long_i = 1'b0, op_sub_i = 1'b0, op_mul_only_i = 1'b0;
  logic        ld_use_mask_i = 1'b0, step = 1'b0, op_ready_o, mul_valid_o;
  logic [1:0]  op_shift_i = 2'h0;
  logic [11:0] reg_sel_i = 12'h000;
  logic [31:0] op_x_i = 32'h0, op_y_i = 32'h0, reg_wdata_i = 32'h0, ld_addr_i;
  logic [31:0] mul_result_o, ld_addr_o, acc_move_o, reg_rdata_o, mres = 32'h0;
  int          failures = 0, compares = 0, cyc = 0;
  mau_core dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .op_long_i(op_long_i),
    .op_sub_i(op_sub_i), .op_mul_only_i(op_mul_only_i), .op_shift_i(op_shift_i),
    .op_x_i(op_x_i), .op_y_i(op_y_i), .op_ready_o(op_ready_o), .mul_valid_o(mul_valid_o),
    .mul_result_o(mul_result_o), .ld_addr_i(ld_addr_i), .ld_use_mask_i(ld_use_mask_i),
    .ld_addr_o(ld_addr_o), .acc_move_o(acc_move_o), .reg_wr_i(reg_wr_i),
    .reg_sel_i(reg_sel_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o));
  mau_ld_partner u_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .step_i(step), .addr_o(ld_addr_i));
  always #12.5 clk_i = ~clk_i;
  // Keep each multiply result, its valid pulse lasts one cycle only
  always @(posedge clk_i) begin
    if (mul_valid_o === 1'b1) mres <= mul_result_o;
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] s, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_sel_i <= s;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // Read data lags the select by one cycle, so wait two edges
  task automatic rd(input logic [11:0] s, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_i);
    reg_sel_i <= s;
    repeat (2) @(posedge clk_i);
    #1 chk(reg_rdata_o & m, e);
  endtask
  // Kind is {long, sub, mul_only, shift}; valid stays up for back-to-back issue
  task automatic op(input logic [4:0] k, input logic [31:0] x, input logic [31:0] y);
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    {op_long_i, op_sub_i, op_mul_only_i, op_shift_i} <= k;
    op_x_i <= x;
    op_y_i <= y;
  endtask
  task automatic idle(input int n);
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(ST, F, 32'h0);
    rd(MK, F, F);
    wr(ST, 32'hFFFF_FF00);
    rd(ST, F, 32'h0);
    wr(MK, 32'hFFFF_FF0F);
    rd(MK, F, 32'hFFFF_FF0F);
    @(posedge clk_i);
    ld_use_mask_i <= 1'b1;
    step <= 1'b1;
    for (int i = 1; i < 4; i++) begin
      @(posedge clk_i);
      #1 chk(ld_addr_o, (32'h0000_10F8 + 32'(4 * i)) & 32'hFFFF_FF0F);
    end
    @(posedge clk_i);
    step <= 1'b0;
    ld_use_mask_i <= 1'b0;
    #1 chk(ld_addr_o, 32'h0000_1108);
    wr(AC, 32'h0000_000A);
    op(5'h00, 32'h0000_FFFC, 32'h0000_0003);
    idle(8);
    rd(AC, F, 32'hFFFF_FFFE);
    op(5'h08, 32'h0000_0005, 32'h0000_0006);
    idle(8);
    rd(AC, F, 32'hFFFF_FFE0);
    wr(AC, 32'h0);
    op(5'h01, 32'h0000_0002, 32'h0000_0003);
    op(5'h02, 32'h0000_0008, 32'h0000_0002);
    idle(8);
    rd(AC, F, 32'h0000_0014);
    wr(ST, 32'h0000_0040);
    op(5'h04, 32'h0000_FFFF, 32'h0000_FFFF);
    idle(8);
    chk(mres, 32'hFFFE_0001);
    op(5'h14, 32'h0001_2345, 32'h0001_0000);
    idle(10);
    chk(mres, 32'h2345_0000);
    wr(ST, 32'h0);
    wr(AC, 32'h7FFF_FFFF);
    op(5'h00, 32'h0000_0001, 32'h0000_0001);
    idle(8);
    rd(AC, F, 32'h8000_0000);
    rd(ST, 32'h2, 32'h2);
    wr(ST, 32'h0000_0080);
    wr(AC, 32'h7FFF_FFF0);
    op(5'h00, 32'h0000_7FFF, 32'h0000_7FFF);
    idle(8);
    op(5'h08, 32'h0000_0001, 32'h0000_0001);
    idle(8);
    rd(AC, F, 32'h7FFF_FFFF);
    // A direct load frees the held accumulator while the flag stays set
    wr(AC, 32'h0000_0010);
    op(5'h00, 32'h0000_0001, 32'h0000_0001);
    idle(8);
    rd(AC, F, 32'h0000_0011);
    wr(ST, 32'h0000_00C0);
    wr(AC, 32'hFFFF_FFF0);
    op(5'h00, 32'h0000_0010, 32'h0000_0010);
    idle(8);
    rd(AC, F, F);
    for (int r = 0; r < 2; r++) begin
      wr(ST, r ? 32'h0000_0020 : 32'h0000_0030);
      wr(AC, 32'h0);
      op(5'h10, 32'h0000_0003, 32'h4000_0000);
      idle(10);
      rd(AC, F, r ? 32'h1 : 32'h2);
    end
    wr(ST, 32'h0000_0060);
    wr(AC, 32'h1235_8000);
    idle(3);
    #1 chk(acc_move_o, 32'h0000_1236);
    rd(AC, F, 32'h1235_8000);
    close_out();
  end
endmodule // mau_core_bench
bind mau_core mau_core_monitor u_mon (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .op_long_i(op_long_i),
  .op_mul_only_i(op_mul_only_i), .op_ready_o(op_ready_o), .mul_valid_o(mul_valid_o),
  .ld_addr_i(ld_addr_i), .ld_use_mask_i(ld_use_mask_i), .ld_addr_o(ld_addr_o),
  .reg_wr_i(reg_wr_i), .reg_sel_i(reg_sel_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o));
`default_nettype wire
